// ===== lrm_pkg.sv
// Package of constants and types for the link recovery exit and message check block
`default_nettype none
package lrm_pkg;
	localparam int unsigned CLK_HZ = 25000000;
	localparam int unsigned BUDGET_MS = 5;
	localparam int unsigned BUDGET_CYC = (CLK_HZ / 1000) * BUDGET_MS;
	localparam int unsigned ACK_TO_MIN_US = 100;
	localparam int unsigned ACK_TO_MAX_US = 200;
	localparam int unsigned ACK_TO_US = 150;
	localparam logic [15:0] ACK_TO_CYC = 16'((CLK_HZ / 1000000) * ACK_TO_US);
	localparam logic [15:0] ACK_TO_RST = 16'h0032;
	// AXI4-Lite register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MSG = 8'h08;
	localparam logic [7:0] REG_ALERT = 8'h0c;
	localparam logic [7:0] REG_ACKTO = 8'h10;
	localparam logic [7:0] REG_SUPP = 8'h14;
	localparam logic [7:0] REG_ROUTES = 8'h18;
	// CTRL field positions
	localparam int unsigned CTRL_EXIT = 0;
	localparam int unsigned CTRL_EXTCAP = 1;
	localparam int unsigned CTRL_EXTEN = 2;
	localparam int unsigned CTRL_RESPONDER = 3;
	localparam int unsigned CTRL_MSGGO = 4;
	localparam int unsigned CTRL_CODE_LO = 8;
	localparam int unsigned CTRL_REPLY_OK = 5;
	localparam logic [31:0] CTRL_RST = 32'h0000_0008;
	localparam logic [31:0] SUPP_RST = 32'hffff_ffff;
	localparam logic [31:0] ROUTES_RST = 32'h0000_0001;
	// Alert codes (arbitrary values)
	localparam logic [7:0] unrecognised_msg_code = 8'h01;
	localparam logic [7:0] short_msg_code = 8'h02;
	localparam logic [7:0] BAD_ROUTE_CODE = 8'h03;
	localparam logic [7:0] TIMING_FAULT_CODE = 8'h04;
	localparam int unsigned NUM_CODES = 32;
	localparam logic [5:0] DEF_LEN = 6'h08;
	typedef enum logic [6:0] {
		EX_IDLE = 7'h01,
		EX_CLR_OPER = 7'h02,
		EX_EXT_OFF = 7'h04,
		EX_PRIV = 7'h08,
		EX_ALERT = 7'h10,
		EX_RESTART = 7'h20,
		EX_DONE = 7'h40
	} lrm_exit_t;
endpackage : lrm_pkg
`default_nettype wire

// ===== lrm_budget_if.sv
// Interface between the recovery timers and the main block
`default_nettype none
interface lrm_budget_if;
	logic lr_rx;
	logic lr_tx;
	logic lr_sent_seen;
	logic disabled;
	logic disable_char;
	logic enabled;
	logic [2:0] overrun;
	modport timer (input lr_rx, lr_tx, disabled, disable_char, enabled, output lr_sent_seen, overrun);
	modport user (output lr_rx, lr_tx, disabled, disable_char, enabled, input lr_sent_seen, overrun);
endinterface : lrm_budget_if
`default_nettype wire

// ===== lrm_budget.sv
// Three 5 ms recovery path budget counters
`default_nettype none
module lrm_budget (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, active low
	lrm_budget_if.timer bi // Recovery events
);
	typedef struct packed {
		logic [2:0] run;
		logic [2:0][22:0] cnt;
		logic rx_seen;
		logic tx_seen;
		logic dis_seen;
		logic loc_dis;
		logic [2:0] ovr;
	} lrm_bud_t;
	lrm_bud_t s_q, s_d;
	logic [2:0] start, stop;
	always_comb
	begin
		s_d = s_q;
		if (bi.lr_rx)
			s_d.rx_seen = 1'b1;
		if (bi.lr_tx)
			s_d.tx_seen = 1'b1;
		if (bi.disable_char)
			s_d.dis_seen = 1'b1;
		if (bi.disabled)
			s_d.loc_dis = 1'b1;
		if (bi.enabled)
		begin
			s_d.rx_seen = 1'b0;
			s_d.tx_seen = 1'b0;
			s_d.dis_seen = 1'b0;
			s_d.loc_dis = 1'b0;
		end
		// Path 0: rx reset to tx reset
		start[0] = bi.lr_rx;
		stop[0] = bi.lr_tx;
		// Path 1: later of both reset frames to disable
		start[1] = (bi.lr_rx | s_q.rx_seen) & (bi.lr_tx | s_q.tx_seen) & ~s_q.loc_dis;
		stop[1] = bi.disabled;
		// Path 2: later of disable chars and local disable to enable
		start[2] = (bi.disable_char | s_q.dis_seen) & (bi.disabled | s_q.loc_dis);
		stop[2] = bi.enabled;
		for (int i = 0; i < 3; i++)
		begin
			if (stop[i])
				s_d.run[i] = 1'b0;
			else if (start[i] & ~s_q.run[i] & ~(i == 1 && s_q.run[1]))
			begin
				s_d.run[i] = 1'b1;
				s_d.cnt[i] = 23'h0;
			end
			if (s_q.run[i] & ~stop[i])
			begin
				if (s_q.cnt[i] == 23'(lrm_pkg::BUDGET_CYC - 1))
				begin
					s_d.ovr[i] = 1'b1;
					s_d.run[i] = 1'b0;
				end
				else
					s_d.cnt[i] = s_q.cnt[i] + 23'h1;
			end
		end
		if (stop[2])
			s_d.ovr = 3'h0;
		if (!aresetn)
			s_d = '0;
	end
	always_ff @(posedge aclk)
		s_q <= s_d;
	assign bi.overrun = s_q.ovr;
	assign bi.lr_sent_seen = s_q.tx_seen;
endmodule : lrm_budget
`default_nettype wire

// ===== lrm_top.sv
// Recovery exit sequencer, management message checker and AXI4-Lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module lrm_top (
	input wire logic aclk, // Clock, 25 MHz
	input wire logic aresetn, // Sync reset, active low
	input wire logic lr_rx_pulse, // Link reset frame received
	input wire logic lr_tx_pulse, // Link reset frame sent
	input wire logic port_disabled, // Port entered disabled state
	input wire logic disable_char, // Disable characters detected
	input wire logic port_enabled, // Port entered enabled state
	input wire logic [7:0] exit_code, // Alert code of the current recovery exit
	input wire logic [31:0] s_axi_awaddr, // AXI write address
	input wire logic s_axi_awvalid, // AXI
	output logic s_axi_awready, // AXI
	input wire logic [31:0] s_axi_wdata, // AXI
	input wire logic [3:0] s_axi_wstrb, // AXI
	input wire logic s_axi_wvalid, // AXI
	output logic s_axi_wready, // AXI
	output logic [1:0] s_axi_bresp, // AXI
	output logic s_axi_bvalid, // AXI
	input wire logic s_axi_bready, // AXI
	input wire logic [31:0] s_axi_araddr, // AXI
	input wire logic s_axi_arvalid, // AXI
	output logic s_axi_arready, // AXI
	output logic [31:0] s_axi_rdata, // AXI
	output logic [1:0] s_axi_rresp, // AXI
	output logic s_axi_rvalid, // AXI
	input wire logic s_axi_rready, // AXI
	output logic port_usable, // Operational flag
	output logic ext_dist_en, // Long-distance option on
	output logic [15:0] ack_timeout_cyc, // Acknowledge time-out in cycles
	output logic privileged, // Transmitter drops application frames
	output logic alert_valid, // One-cycle request to the alert process
	output logic [7:0] alert_code, // Alert code with alert_valid
	output logic port_restart, // One-cycle port restart request
	output logic reply_en, // One-cycle: message may be answered
	output logic timing_fault // A 5 ms budget overran
);
	typedef struct packed {
		lrm_pkg::lrm_exit_t ex;
		logic in_exit;
		logic usable;
		logic ext_en;
		logic [15:0] ackto;
		logic priv;
		logic aval;
		logic [7:0] acode;
		logic restart;
		logic reply;
		logic tfault;
		logic [7:0] exit_code;
		logic [31:0] ctrl;
		logic [31:0] supp;
		logic [31:0] routes;
		logic [31:0] msg;
		logic [7:0] last_alert;
		logic aw_ok;
		logic [7:0] awaddr;
		logic w_ok;
		logic [31:0] wdata;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} lrm_state_t;
	lrm_state_t s_q, s_d;
	lrm_budget_if bi ();
	assign bi.lr_rx = lr_rx_pulse;
	assign bi.lr_tx = lr_tx_pulse;
	assign bi.disabled = port_disabled;
	assign bi.disable_char = disable_char;
	assign bi.enabled = port_enabled;
	lrm_budget u_budget (
		.aclk(aclk),
		.aresetn(aresetn),
		.bi(bi)
	);
	// Message field unpacking: msg register = {len[13:8], frame_ok[14], known[15], route[20:16], code[4:0]}
	logic [4:0] m_code;
	logic [5:0] m_len;
	logic m_frame_ok;
	logic m_known;
	logic [4:0] m_route;
	logic alert_fire;
	logic [7:0] alert_fire_code;
	logic [7:0] rd;
	logic [31:0] rword;
	assign m_code = s_q.msg[4:0];
	assign m_len = s_q.msg[13:8];
	assign m_frame_ok = s_q.msg[14];
	assign m_known = s_q.msg[15];
	assign m_route = s_q.msg[20:16];
	always_comb
	begin
		s_d = s_q;
		s_d.aval = 1'b0;
		s_d.restart = 1'b0;
		s_d.reply = 1'b0;
		alert_fire = 1'b0;
		alert_fire_code = 8'h00;
		if (|bi.overrun)
			s_d.tfault = 1'b1;
		// Exit sequence; a new exit request is ignored while one runs
		case (s_q.ex)
			lrm_pkg::EX_IDLE:
				if (s_q.ctrl[lrm_pkg::CTRL_EXIT])
				begin
					s_d.exit_code = exit_code;
					s_d.in_exit = 1'b1;
					s_d.ex = lrm_pkg::EX_CLR_OPER;
				end
			lrm_pkg::EX_CLR_OPER:
			begin
				s_d.usable = 1'b0;
				s_d.ex = lrm_pkg::EX_EXT_OFF;
			end
			lrm_pkg::EX_EXT_OFF:
			begin
				if (s_q.ctrl[lrm_pkg::CTRL_EXTCAP])
				begin
					s_d.ext_en = 1'b0;
					s_d.ackto = lrm_pkg::ACK_TO_CYC;
				end
				s_d.ex = lrm_pkg::EX_PRIV;
			end
			lrm_pkg::EX_PRIV:
			begin
				s_d.priv = 1'b1;
				s_d.ex = lrm_pkg::EX_ALERT;
			end
			lrm_pkg::EX_ALERT:
			begin
				alert_fire = 1'b1;
				alert_fire_code = s_q.exit_code;
				s_d.ex = lrm_pkg::EX_RESTART;
			end
			lrm_pkg::EX_RESTART:
			begin
				s_d.restart = 1'b1;
				s_d.ex = lrm_pkg::EX_DONE;
			end
			lrm_pkg::EX_DONE:
			begin
				s_d.in_exit = 1'b0;
				s_d.ex = lrm_pkg::EX_IDLE;
			end
			default:
				s_d.ex = lrm_pkg::EX_IDLE;
		endcase
		// Message check, ordered; exit alert has priority, message waits one cycle
		if (s_q.ctrl[lrm_pkg::CTRL_MSGGO] && !alert_fire)
		begin
			s_d.ctrl[lrm_pkg::CTRL_MSGGO] = 1'b0;
			if (!m_known)
			begin
				alert_fire = 1'b1;
				alert_fire_code = lrm_pkg::unrecognised_msg_code;
			end
			else if (!s_q.supp[m_code] || !m_frame_ok)
			begin
				alert_fire = 1'b1;
				alert_fire_code = lrm_pkg::unrecognised_msg_code;
			end
			else if (m_len < lrm_pkg::DEF_LEN)
			begin
				alert_fire = 1'b1;
				alert_fire_code = lrm_pkg::short_msg_code;
			end
			else if (!s_q.routes[m_route])
			begin
				alert_fire = s_q.ctrl[lrm_pkg::CTRL_RESPONDER];
				alert_fire_code = lrm_pkg::BAD_ROUTE_CODE;
			end
			else
				s_d.reply = 1'b1;
		end
		if (alert_fire)
		begin
			s_d.aval = 1'b1;
			s_d.acode = alert_fire_code;
			s_d.last_alert = alert_fire_code;
		end
		// Exit request bit self-clears once the sequence has taken it
		if (s_q.ex == lrm_pkg::EX_IDLE)
			s_d.ctrl[lrm_pkg::CTRL_EXIT] = 1'b0;
		// AXI4-Lite write
		if (s_axi_awvalid && !s_q.aw_ok && !s_q.bvalid)
		begin
			s_d.aw_ok = 1'b1;
			s_d.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && !s_q.w_ok && !s_q.bvalid)
		begin
			s_d.w_ok = 1'b1;
			s_d.wdata = s_axi_wdata;
		end
		if (s_q.aw_ok && s_q.w_ok)
		begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = 2'b00;
			case (s_q.awaddr)
				lrm_pkg::REG_CTRL:
				begin
					s_d.ctrl = s_q.wdata;
					// Hardware-owned exit bit: a write cannot re-enter a running sequence
					if (s_q.ex != lrm_pkg::EX_IDLE)
						s_d.ctrl[lrm_pkg::CTRL_EXIT] = 1'b0;
					s_d.ext_en = s_q.wdata[lrm_pkg::CTRL_EXTEN];
				end
				lrm_pkg::REG_STATUS:
				begin
					// Write one to clear the timing fault; ignored while any budget overrun flag is still set
					if (s_q.wdata[4] && ~|bi.overrun)
						s_d.tfault = 1'b0;
					if (s_q.wdata[0])
						s_d.usable = 1'b1;
					if (s_q.wdata[2])
						s_d.priv = 1'b0;
				end
				lrm_pkg::REG_MSG: s_d.msg = s_q.wdata;
				lrm_pkg::REG_ACKTO: s_d.ackto = s_q.wdata[15:0];
				lrm_pkg::REG_SUPP: s_d.supp = s_q.wdata;
				lrm_pkg::REG_ROUTES: s_d.routes = s_q.wdata;
				default: s_d.bresp = 2'b10;
			endcase
		end
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		// AXI4-Lite read
		rd = s_axi_araddr[7:0];
		rword = 32'h0;
		case (rd)
			lrm_pkg::REG_CTRL: rword = s_q.ctrl;
			lrm_pkg::REG_STATUS: rword = {24'h0, 3'h0, s_q.tfault, s_q.in_exit, s_q.priv,
				s_q.ext_en, s_q.usable};
			lrm_pkg::REG_MSG: rword = s_q.msg;
			lrm_pkg::REG_ALERT: rword = {24'h0, s_q.last_alert};
			lrm_pkg::REG_ACKTO: rword = {16'h0, s_q.ackto};
			lrm_pkg::REG_SUPP: rword = s_q.supp;
			lrm_pkg::REG_ROUTES: rword = s_q.routes;
			default: rword = 32'h0;
		endcase
		if (s_axi_arvalid && !s_q.rvalid)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rword;
			s_d.rresp = (rd == lrm_pkg::REG_CTRL || rd == lrm_pkg::REG_STATUS
				|| rd == lrm_pkg::REG_MSG || rd == lrm_pkg::REG_ALERT
				|| rd == lrm_pkg::REG_ACKTO || rd == lrm_pkg::REG_SUPP
				|| rd == lrm_pkg::REG_ROUTES) ? 2'b00 : 2'b10;
		end
		else if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (!aresetn)
		begin
			s_d = '0;
			s_d.ex = lrm_pkg::EX_IDLE;
			s_d.usable = 1'b1;
			s_d.ackto = lrm_pkg::ACK_TO_RST;
			s_d.ctrl = lrm_pkg::CTRL_RST;
			s_d.supp = lrm_pkg::SUPP_RST;
			s_d.routes = lrm_pkg::ROUTES_RST;
		end
	end
	always_ff @(posedge aclk)
		s_q <= s_d;
	assign s_axi_awready = s_axi_awvalid && !s_q.aw_ok && !s_q.bvalid;
	assign s_axi_wready = s_axi_wvalid && !s_q.w_ok && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_axi_arvalid && !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign port_usable = s_q.usable;
	assign ext_dist_en = s_q.ext_en;
	assign ack_timeout_cyc = s_q.ackto;
	assign privileged = s_q.priv;
	assign alert_valid = s_q.aval;
	assign alert_code = s_q.acode;
	assign port_restart = s_q.restart;
	assign reply_en = s_q.reply;
	assign timing_fault = s_q.tfault;
endmodule : lrm_top
`default_nettype wire

// ===== lrm_monitor.sv
// Checker for exit sequencing and message results at the block's ports
`default_nettype none
module lrm_monitor (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, active low
	input wire logic lr_rx_pulse, // Link reset frame received
	input wire logic [7:0] exit_code, // Exit alert code
	input wire logic port_usable, // Operational flag
	input wire logic ext_dist_en, // Long-distance option
	input wire logic [15:0] ack_timeout_cyc, // Ack time-out
	input wire logic privileged, // Privileged mode
	input wire logic alert_valid, // Alert request
	input wire logic [7:0] alert_code, // Alert code
	input wire logic port_restart, // Restart request
	input wire logic reply_en, // Reply allowed
	input wire logic timing_fault // Budget overrun
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	usable_first_a: assert property ($fell(port_usable) |-> !privileged ##1 !privileged ##1 privileged)
		else $error("usable flag not cleared two cycles before privileged mode");
	ext_off_a: assert property ($rose(privileged) |-> !ext_dist_en && !port_usable)
		else $error("option still on at privileged mode");
	ack_set_a: assert property ($changed(ack_timeout_cyc) && !port_usable |->
		ack_timeout_cyc == lrm_pkg::ACK_TO_CYC) else $error("exit ack time-out out of range");
	alert_code_a: assert property ($rose(privileged) |=> alert_valid && alert_code == exit_code)
		else $error("exit alert missing or wrong code");
	restart_last_a: assert property ($rose(privileged) |=> ##1 port_restart)
		else $error("restart not last step");
	restart_pulse_a: assert property (port_restart |=> !port_restart && privileged)
		else $error("restart not a single pulse");
	reply_clean_a: assert property (reply_en |-> !alert_valid)
		else $error("reply together with alert");
	fault_quiet_a: assert property (lr_rx_pulse && !timing_fault |=> !timing_fault [*8])
		else $error("early timing fault");
	cover property ($rose(privileged));
	cover property (reply_en);
	cover property (alert_valid && alert_code == lrm_pkg::short_msg_code);
endmodule : lrm_monitor
`default_nettype wire

// ===== lrm_remote.sv
// Model of one recovery round as seen from the link, events spaced by gap
`default_nettype none
module lrm_remote (
	input wire logic aclk, // Clock
	input wire logic go, // Start one round
	input wire logic [7:0] gap, // Cycles between events
	output logic lr_rx_pulse, // Link reset received
	output logic lr_tx_pulse, // Link reset sent
	output logic port_disabled, // Disabled state entered
	output logic disable_char // Disable characters seen
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		lr_rx_pulse = 1'b0;
		lr_tx_pulse = 1'b0;
		port_disabled = 1'b0;
		disable_char = 1'b0;
	end
	always
	begin
		@(posedge aclk iff go);
		lr_rx_pulse <= 1'b1;
		@(posedge aclk);
		lr_rx_pulse <= 1'b0;
		repeat (gap) @(posedge aclk);
		lr_tx_pulse <= 1'b1;
		@(posedge aclk);
		lr_tx_pulse <= 1'b0;
		repeat (gap) @(posedge aclk);
		port_disabled <= 1'b1;
		@(posedge aclk);
		port_disabled <= 1'b0;
		repeat (gap) @(posedge aclk);
		disable_char <= 1'b1;
		@(posedge aclk);
		disable_char <= 1'b0;
	end
endmodule : lrm_remote
`default_nettype wire

// ===== testbench.sv
// Register-level bench for recovery exit and message checks
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = 1'b0, rstn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rd;
	logic [7:0] ecode = 8'h5a, gap = 8'h03, seen_a;
	logic go = 1'b0, pen = 1'b0, seen_r, seen_rst;
	logic [1:0] rsp;
	wire logic lrx, ltx, pdis, dch, awr, wr, bv, arr, rv, usable, ext, priv, av, rst, rep, tf;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [15:0] ackto;
	wire logic [7:0] acode;
	int bad_count = 0, n_tests = 0;
	always #20 aclk = ~aclk;
	lrm_remote lrm_remote_inst (.aclk(aclk), .go(go), .gap(gap), .lr_rx_pulse(lrx),
		.lr_tx_pulse(ltx), .port_disabled(pdis), .disable_char(dch));
	lrm_top lrm_top_inst (.aclk(aclk), .aresetn(rstn), .lr_rx_pulse(lrx), .lr_tx_pulse(ltx),
		.port_disabled(pdis), .disable_char(dch), .port_enabled(pen), .exit_code(ecode),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .port_usable(usable), .ext_dist_en(ext), .ack_timeout_cyc(ackto),
		.privileged(priv), .alert_valid(av), .alert_code(acode), .port_restart(rst),
		.reply_en(rep), .timing_fault(tf));
	// Sticky capture, since one-cycle results may land while a bus cycle is still open
	always @(posedge aclk)
	begin
		if (av) seen_a <= acode;
		if (rep) seen_r <= 1'b1;
		if (rst) seen_rst <= 1'b1;
	end
	task automatic final_report;
		$display("Compares %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
			bad_count++;
		end
	endtask : check
	// Handshakes are judged at the rising edge itself, before the design's registers update
	task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		for (int i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (awv && awr)
				awv <= 1'b0;
			if (wv && wr)
				wv <= 1'b0;
			if (bv)
			begin
				rsp = bresp;
				br <= 1'b0;
				return;
			end
		end
		bad_count++;
		final_report();
	endtask : axi_wr
	task automatic axi_rd(input logic [31:0] a);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		for (int i = 0; i < 100; i++)
		begin
			@(posedge aclk);
			if (arv && arr)
				arv <= 1'b0;
			if (rv)
			begin
				rd = rdata;
				rsp = rresp;
				rr <= 1'b0;
				return;
			end
		end
		bad_count++;
		final_report();
	endtask : axi_rd
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		axi_rd(a);
		check(rd, exp);
	endtask : rd_chk
	function automatic logic [31:0] m(logic kn, logic fok, logic [5:0] len, logic [4:0] rt);
		return {11'h0, rt, kn, fok, len, 3'h0, 5'h03};
	endfunction : m
	task automatic run_msg(input logic [31:0] msg, input logic [31:0] supp,
		input logic [31:0] rts, input logic [31:0] ctl, input logic [7:0] ea, input logic er);
		axi_wr(lrm_pkg::REG_SUPP, supp);
		axi_wr(lrm_pkg::REG_ROUTES, rts);
		axi_wr(lrm_pkg::REG_MSG, msg);
		@(posedge aclk);
		seen_a <= 8'h00;
		seen_r <= 1'b0;
		axi_wr(lrm_pkg::REG_CTRL, ctl);
		repeat (4) @(negedge aclk);
		check({23'h0, seen_r, seen_a}, {23'h0, er, ea});
	endtask : run_msg
	initial
	begin
		repeat (5) @(posedge aclk);
		rstn <= 1'b1;
		rd_chk(lrm_pkg::REG_STATUS, 32'h1);
		rd_chk(lrm_pkg::REG_ACKTO, {16'h0, lrm_pkg::ACK_TO_RST});
		rd_chk(lrm_pkg::REG_CTRL, lrm_pkg::CTRL_RST);
		rd_chk(lrm_pkg::REG_SUPP, lrm_pkg::SUPP_RST);
		rd_chk(lrm_pkg::REG_ROUTES, lrm_pkg::ROUTES_RST);
		rd_chk(32'h40, 32'h0);
		check({30'h0, rsp}, 32'h2);
		axi_wr(32'h40, 32'h1);
		check({30'h0, rsp}, 32'h2);
		$display("Test registers done");
		axi_wr(lrm_pkg::REG_CTRL, 32'h0e);
		@(posedge aclk);
		seen_a <= 8'h00;
		seen_rst <= 1'b0;
		axi_wr(lrm_pkg::REG_CTRL, 32'h0f);
		repeat (10) @(negedge aclk);
		check({24'h0, seen_a}, {24'h0, ecode});
		check({31'h0, seen_rst}, 32'h1);
		check({16'h0, ackto}, {16'h0, lrm_pkg::ACK_TO_CYC});
		rd_chk(lrm_pkg::REG_STATUS, 32'h4);
		rd_chk(lrm_pkg::REG_ALERT, {24'h0, ecode});
		axi_wr(lrm_pkg::REG_STATUS, 32'h5);
		// A port without the option keeps its programmed time-out
		axi_wr(lrm_pkg::REG_ACKTO, 32'h32);
		axi_wr(lrm_pkg::REG_CTRL, 32'h09);
		repeat (10) @(negedge aclk);
		rd_chk(lrm_pkg::REG_ACKTO, 32'h32);
		rd_chk(lrm_pkg::REG_STATUS, 32'h4);
		axi_wr(lrm_pkg::REG_STATUS, 32'h5);
		rd_chk(lrm_pkg::REG_STATUS, 32'h1);
		$display("Test exit done");
		run_msg(m(0, 1, 8, 2), '1, 32'h5, 32'h18, lrm_pkg::unrecognised_msg_code, 0);
		run_msg(m(1, 1, 8, 2), 32'hfffffff7, 32'h5, 32'h18, lrm_pkg::unrecognised_msg_code, 0);
		run_msg(m(1, 0, 8, 2), '1, 32'h5, 32'h18, lrm_pkg::unrecognised_msg_code, 0);
		run_msg(m(1, 1, 7, 2), '1, 32'h5, 32'h18, lrm_pkg::short_msg_code, 0);
		run_msg(m(1, 1, 6'h3f, 2), '1, 32'h5, 32'h18, 8'h00, 1);
		run_msg(m(1, 1, 8, 2), '1, 32'h1, 32'h18, lrm_pkg::BAD_ROUTE_CODE, 0);
		run_msg(m(1, 1, 8, 2), '1, 32'h1, 32'h10, 8'h00, 0);
		run_msg(m(0, 1, 7, 2), '1, 32'h1, 32'h18, lrm_pkg::unrecognised_msg_code, 0);
		run_msg(m(1, 0, 7, 2), '1, 32'h5, 32'h18, lrm_pkg::unrecognised_msg_code, 0);
		run_msg(m(1, 1, 7, 2), '1, 32'h1, 32'h18, lrm_pkg::short_msg_code, 0);
		$display("Test messages done");
		for (int k = 0; k < 2; k++)
		begin
			@(posedge aclk);
			gap <= k ? 8'hc8 : 8'h03;
			go <= 1'b1;
			@(posedge aclk);
			go <= 1'b0;
			repeat (900) @(posedge aclk);
			pen <= 1'b1;
			@(posedge aclk);
			pen <= 1'b0;
		end
		rd_chk(lrm_pkg::REG_STATUS, 32'h1);
		$display("Test budgets done");
		final_report();
	end
endmodule : testbench
bind lrm_top lrm_monitor lrm_monitor_inst (.aclk(aclk), .aresetn(aresetn),
	.lr_rx_pulse(lr_rx_pulse), .exit_code(exit_code), .port_usable(port_usable),
	.ext_dist_en(ext_dist_en), .ack_timeout_cyc(ack_timeout_cyc), .privileged(privileged),
	.alert_valid(alert_valid), .alert_code(alert_code), .port_restart(port_restart),
	.reply_en(reply_en), .timing_fault(timing_fault));
`default_nettype wire
